// ### hw/dpbs_pkg.sv
/*
  Shared constants and helpers for the dual-port block RAM.
  Assumes one clock domain for both ports and the register bus.
*/
package dpbs_pkg;

  // ----------------------------------------
  // Array shape
  // ----------------------------------------
  localparam int DPBS_ADDR_W = 12;
  localparam int DPBS_DATA_W = 9;
  localparam int DPBS_WORDS  = 512;
  localparam int DPBS_BITS   = 4608;
  localparam int DPBS_IDX_W  = 9;
  localparam int DPBS_LSB_W  = 4;

  // ----------------------------------------
  // Width select codes
  // ----------------------------------------
  localparam logic [1:0] DPBS_W1 = 2'h0;
  localparam logic [1:0] DPBS_W2 = 2'h1;
  localparam logic [1:0] DPBS_W4 = 2'h2;
  localparam logic [1:0] DPBS_W9 = 2'h3;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [31:0] DPBS_CFG_OFS  = 32'h0000_0000;
  localparam logic [31:0] DPBS_STAT_OFS = 32'h0000_0004;
  localparam int          DPBS_CFG_W    = 12;
  localparam logic [11:0] DPBS_CFG_RST  = 12'h000;
  localparam int          DPBS_A_WID    = 0;
  localparam int          DPBS_A_PIPE   = 2;
  localparam int          DPBS_A_WMODE  = 3;
  localparam int          DPBS_B_WID    = 8;
  localparam int          DPBS_B_PIPE   = 10;
  localparam int          DPBS_B_WMODE  = 11;
  localparam int          DPBS_STAT_B   = 16;

  // ----------------------------------------
  // Address and lane helpers
  // ----------------------------------------
  function automatic logic [8:0] dpbs_width_mask(input logic [1:0] w);
    case (w)
      DPBS_W1: dpbs_width_mask = 9'h001;
      DPBS_W2: dpbs_width_mask = 9'h003;
      DPBS_W4: dpbs_width_mask = 9'h00F;
      default: dpbs_width_mask = 9'h1FF;
    endcase
  endfunction

  function automatic logic [8:0] dpbs_word_index(input logic [11:0] a, input logic [1:0] w);
    case (w)
      DPBS_W1: dpbs_word_index = a[11:3];
      DPBS_W2: dpbs_word_index = a[10:2];
      DPBS_W4: dpbs_word_index = a[9:1];
      default: dpbs_word_index = a[8:0];
    endcase
  endfunction

  function automatic logic [3:0] dpbs_slot_lsb(input logic [11:0] a, input logic [1:0] w);
    case (w)
      DPBS_W1: dpbs_slot_lsb = {1'b0, a[2:0]};
      DPBS_W2: dpbs_slot_lsb = {1'b0, a[1:0], 1'b0};
      DPBS_W4: dpbs_slot_lsb = {1'b0, a[0], 2'b00};
      default: dpbs_slot_lsb = 4'h0;
    endcase
  endfunction

  function automatic logic [8:0] dpbs_extract(input logic [8:0] word, input logic [11:0] a,
                                              input logic [1:0] w);
    dpbs_extract = 9'(word >> dpbs_slot_lsb(a, w)) & dpbs_width_mask(w);
  endfunction

endpackage

// ### hw/dpbs_mem.sv
/*
  Storage array of the dual-port block RAM, 512 words of 9 bits.
  Assumes write enables are already gated by the ports; no reset.
*/
`timescale 1ns/1ps
module dpbs_mem
  import dpbs_pkg::*;
#(
  parameter int WORDS  = DPBS_WORDS,
  parameter int DATA_W = DPBS_DATA_W,
  parameter int IDX_W  = DPBS_IDX_W
) (
  input  wire logic              hclk,
  input  wire logic              we_a,
  input  wire logic [IDX_W-1:0]  idx_a,
  input  wire logic [DATA_W-1:0] mask_a,
  input  wire logic [DATA_W-1:0] wdata_a,
  output logic      [DATA_W-1:0] rdata_a,
  input  wire logic              we_b,
  input  wire logic [IDX_W-1:0]  idx_b,
  input  wire logic [DATA_W-1:0] mask_b,
  input  wire logic [DATA_W-1:0] wdata_b,
  output logic      [DATA_W-1:0] rdata_b
);

  typedef struct packed {
    logic [WORDS-1:0][DATA_W-1:0] words;
  } dpbs_mem_t;

  dpbs_mem_t st_q;
  dpbs_mem_t st_d;

  // ----------------------------------------
  // Masked writes, port B applied last
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    if (we_a) begin
      st_d.words[idx_a] = (st_q.words[idx_a] & ~mask_a) | (wdata_a & mask_a);
    end
    if (we_b) begin
      st_d.words[idx_b] = (st_d.words[idx_b] & ~mask_b) | (wdata_b & mask_b);
    end
  end

  // Contents survive reset
  always_ff @(posedge hclk) begin
    st_q <= st_d;
  end

  assign rdata_a = st_q.words[idx_a];
  assign rdata_b = st_q.words[idx_b];

endmodule

// ### hw/dpbs_port.sv
/*
  One access port: address decode, write lanes, read hold and output.
  Assumes port signals come from logic on the same clock.
*/
`timescale 1ns/1ps
module dpbs_port
  import dpbs_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        select_n,
  input  wire logic        read_write_n,
  input  wire logic [11:0] address,
  input  wire logic [8:0]  wdata,
  input  wire logic [1:0]  width_select,
  input  wire logic        pipeline_select,
  input  wire logic        write_through,
  input  wire logic [8:0]  rword,
  output logic             mem_we,
  output logic      [8:0]  mem_idx,
  output logic      [8:0]  mem_mask,
  output logic      [8:0]  mem_wdata,
  output logic      [8:0]  rdata
);

  typedef struct packed {
    logic [8:0] hold;
    logic [8:0] dout;
  } dpbs_port_t;

  dpbs_port_t st_q;
  dpbs_port_t st_d;
  logic [3:0] lsb;
  logic [8:0] wmask;

  // ----------------------------------------
  // Lane decode
  // ----------------------------------------
  assign lsb       = dpbs_slot_lsb(address, width_select);
  assign wmask     = dpbs_width_mask(width_select);
  assign mem_idx   = dpbs_word_index(address, width_select);
  assign mem_mask  = 9'(wmask << lsb);
  assign mem_wdata = 9'((wdata & wmask) << lsb);
  assign mem_we    = hresetn && !select_n && !read_write_n;

  // ----------------------------------------
  // Hold and output
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    if (!select_n) begin
      if (read_write_n) begin
        st_d.hold = dpbs_extract(rword, address, width_select);
      end else if (write_through) begin
        st_d.hold = wdata & wmask;
      end
    end
    st_d.dout = pipeline_select ? st_q.hold : st_d.hold;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata = st_q.dout;

endmodule

// ### hw/dpbs_top.sv
/*
  Dual-port block RAM with an AHB-Lite register slave for port setup.
  Assumes both ports and the bus share hclk; port pins are from
  logic on that clock.
*/
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module dpbs_top
  import dpbs_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        port_a_select_n,
  input  wire logic        port_a_read_write_n,
  input  wire logic [11:0] port_a_address,
  input  wire logic [8:0]  port_a_wdata,
  output logic      [8:0]  port_a_rdata,
  input  wire logic        port_b_select_n,
  input  wire logic        port_b_read_write_n,
  input  wire logic [11:0] port_b_address,
  input  wire logic [8:0]  port_b_wdata,
  output logic      [8:0]  port_b_rdata
);

  typedef struct packed {
    logic [DPBS_CFG_W-1:0] cfg;
    logic                  wr_cfg;
    logic [31:0]           rdata;
    logic                  ready;
    logic                  resp;
  } dpbs_bus_t;

  dpbs_bus_t st_q;
  dpbs_bus_t st_d;

  logic       take;
  logic [1:0] wid_a;
  logic [1:0] wid_b;
  logic       pipe_a;
  logic       pipe_b;
  logic       wmode_a;
  logic       wmode_b;
  logic       we_a;
  logic       we_b;
  logic [8:0] idx_a;
  logic [8:0] idx_b;
  logic [8:0] mask_a;
  logic [8:0] mask_b;
  logic [8:0] mw_a;
  logic [8:0] mw_b;
  logic [8:0] rword_a;
  logic [8:0] rword_b;

  // ----------------------------------------
  // Register read mux
  // ----------------------------------------
  function automatic logic [31:0] dpbs_read_reg(input logic [31:0] a,
                                                input logic [DPBS_CFG_W-1:0] cfg,
                                                input logic [8:0] da,
                                                input logic [8:0] db);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (a == DPBS_CFG_OFS) begin
      r[DPBS_CFG_W-1:0] = cfg;
    end else if (a == DPBS_STAT_OFS) begin
      r[8:0] = da;
      r[DPBS_STAT_B +: 9] = db;
    end
    return r;
  endfunction

  // ----------------------------------------
  // Port setup fields
  // ----------------------------------------
  assign wid_a   = st_q.cfg[DPBS_A_WID +: 2];
  assign wid_b   = st_q.cfg[DPBS_B_WID +: 2];
  assign pipe_a  = st_q.cfg[DPBS_A_PIPE];
  assign pipe_b  = st_q.cfg[DPBS_B_PIPE];
  assign wmode_a = st_q.cfg[DPBS_A_WMODE];
  assign wmode_b = st_q.cfg[DPBS_B_WMODE];

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  assign take = hsel && hready && htrans[1];

  always_comb begin
    st_d = st_q;
    st_d.ready = 1'b1;
    st_d.resp = 1'b0;
    if (st_q.wr_cfg) begin
      st_d.cfg = hwdata[DPBS_CFG_W-1:0];
    end
    st_d.wr_cfg = take && hwrite && (haddr == DPBS_CFG_OFS);
    st_d.rdata = 32'h0000_0000;
    if (take && !hwrite) begin
      st_d.rdata = dpbs_read_reg(haddr, st_d.cfg, port_a_rdata, port_b_rdata);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
      st_q.cfg <= DPBS_CFG_RST;
      st_q.ready <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign hrdata    = st_q.rdata;
  assign hreadyout = st_q.ready;
  assign hresp     = st_q.resp;

  // ----------------------------------------
  // Ports and array
  // ----------------------------------------
  dpbs_port u_port_a (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .select_n        (port_a_select_n),
    .read_write_n    (port_a_read_write_n),
    .address         (port_a_address),
    .wdata           (port_a_wdata),
    .width_select    (wid_a),
    .pipeline_select (pipe_a),
    .write_through   (wmode_a),
    .rword           (rword_a),
    .mem_we          (we_a),
    .mem_idx         (idx_a),
    .mem_mask        (mask_a),
    .mem_wdata       (mw_a),
    .rdata           (port_a_rdata)
  );

  dpbs_port u_port_b (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .select_n        (port_b_select_n),
    .read_write_n    (port_b_read_write_n),
    .address         (port_b_address),
    .wdata           (port_b_wdata),
    .width_select    (wid_b),
    .pipeline_select (pipe_b),
    .write_through   (wmode_b),
    .rword           (rword_b),
    .mem_we          (we_b),
    .mem_idx         (idx_b),
    .mem_mask        (mask_b),
    .mem_wdata       (mw_b),
    .rdata           (port_b_rdata)
  );

  dpbs_mem #(
    .WORDS  (DPBS_WORDS),
    .DATA_W (DPBS_DATA_W),
    .IDX_W  (DPBS_IDX_W)
  ) u_mem (
    .hclk    (hclk),
    .we_a    (we_a),
    .idx_a   (idx_a),
    .mask_a  (mask_a),
    .wdata_a (mw_a),
    .rdata_a (rword_a),
    .we_b    (we_b),
    .idx_b   (idx_b),
    .mask_b  (mask_b),
    .wdata_b (mw_b),
    .rdata_b (rword_b)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [8:0] exp_a;
  logic [8:0] exp_b;
  logic [8:0] thru_a;

  assign exp_a  = dpbs_extract(rword_a, port_a_address, wid_a);
  assign exp_b  = dpbs_extract(rword_b, port_b_address, wid_b);
  assign thru_a = port_a_wdata & dpbs_width_mask(wid_a);

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_rst_out;
    $rose(hresetn) |-> port_a_rdata == 9'h000 && port_b_rdata == 9'h000 && hrdata == 32'h0000_0000;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not zero after reset");

  property p_sel_hold;
    port_a_select_n ##1 port_a_select_n |=> $stable(port_a_rdata);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("port A output moved while idle");

  property p_rd_a;
    !port_a_select_n && port_a_read_write_n && !pipe_a |=> port_a_rdata == $past(exp_a);
  endproperty
  a_rd_a: assert property (p_rd_a) else $error("port A read data wrong");

  property p_pipe_a;
    (!port_a_select_n && port_a_read_write_n && pipe_a) ##1 pipe_a |=> port_a_rdata == $past(exp_a, 2);
  endproperty
  a_pipe_a: assert property (p_pipe_a) else $error("port A pipelined read wrong");

  property p_thru_a;
    !port_a_select_n && !port_a_read_write_n && wmode_a && !pipe_a |=> port_a_rdata == $past(thru_a);
  endproperty
  a_thru_a: assert property (p_thru_a) else $error("write-through data wrong");

  property p_keep_a;
    !port_a_select_n && !port_a_read_write_n && !wmode_a && !pipe_a && $stable(st_q.cfg)
      |=> $stable(port_a_rdata);
  endproperty
  a_keep_a: assert property (p_keep_a) else $error("retaining write changed output");

  property p_mask_a;
    we_a |-> $countones(mask_a) == ((wid_a == DPBS_W9) ? 9 : (1 << wid_a));
  endproperty
  a_mask_a: assert property (p_mask_a) else $error("write lanes do not match width");

  property p_rd_b;
    !port_b_select_n && port_b_read_write_n && !pipe_b |=> port_b_rdata == $past(exp_b);
  endproperty
  a_rd_b: assert property (p_rd_b) else $error("port B read data wrong");

  property p_bus_wr;
    take && hwrite && haddr == DPBS_CFG_OFS ##1 1'b1 |=> st_q.cfg == $past(hwdata[DPBS_CFG_W-1:0]);
  endproperty
  a_bus_wr: assert property (p_bus_wr) else $error("setup register not written");

  property p_bus_rd;
    take && !hwrite && haddr == DPBS_STAT_OFS |=> hrdata[8:0] == $past(port_a_rdata);
  endproperty
  a_bus_rd: assert property (p_bus_rd) else $error("status read wrong");

  // ----------------------------------------
  // Port B, lane, array and bus checks
  // ----------------------------------------
  logic [8:0] thru_b;

  assign thru_b = port_b_wdata & dpbs_width_mask(wid_b);

  property p_sel_hold_b;
    port_b_select_n ##1 port_b_select_n |=> $stable(port_b_rdata);
  endproperty
  a_sel_hold_b: assert property (p_sel_hold_b) else $error("port B output moved while idle");

  property p_pipe_b;
    (!port_b_select_n && port_b_read_write_n && pipe_b) ##1 pipe_b |=> port_b_rdata == $past(exp_b, 2);
  endproperty
  a_pipe_b: assert property (p_pipe_b) else $error("port B pipelined read wrong");

  property p_thru_b;
    !port_b_select_n && !port_b_read_write_n && wmode_b && !pipe_b |=> port_b_rdata == $past(thru_b);
  endproperty
  a_thru_b: assert property (p_thru_b) else $error("port B write-through data wrong");

  property p_keep_b;
    !port_b_select_n && !port_b_read_write_n && !wmode_b && !pipe_b && $stable(st_q.cfg)
      |=> $stable(port_b_rdata);
  endproperty
  a_keep_b: assert property (p_keep_b) else $error("port B retaining write changed output");

  property p_mask_b;
    we_b |-> $countones(mask_b) == ((wid_b == DPBS_W9) ? 9 : (1 << wid_b));
  endproperty
  a_mask_b: assert property (p_mask_b) else $error("port B write lanes do not match width");

  property p_lane_a;
    !port_a_select_n && port_a_read_write_n && !pipe_a
      |=> (port_a_rdata & ~dpbs_width_mask($past(wid_a))) == 9'h000;
  endproperty
  a_lane_a: assert property (p_lane_a) else $error("port A read shows unused bits");

  property p_wr_a;
    we_a && !(we_b && idx_b == idx_a)
      |=> (u_mem.st_q.words[$past(idx_a)] & $past(mask_a)) == $past(mw_a);
  endproperty
  a_wr_a: assert property (p_wr_a) else $error("port A write did not land");

  property p_wr_b;
    we_b |=> (u_mem.st_q.words[$past(idx_b)] & $past(mask_b)) == $past(mw_b);
  endproperty
  a_wr_b: assert property (p_wr_b) else $error("port B write did not land");

  property p_rst_block;
    disable iff (1'b0) !hresetn |-> !we_a && !we_b;
  endproperty
  a_rst_block: assert property (p_rst_block) else $error("array written during reset");

  property p_rd_idle;
    !(take && !hwrite) |=> hrdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data left on bus");

  property p_cfg_keep;
    !st_q.wr_cfg |=> $stable(st_q.cfg);
  endproperty
  a_cfg_keep: assert property (p_cfg_keep) else $error("setup register changed without write");

  property p_stat_b;
    take && !hwrite && haddr == DPBS_STAT_OFS |=> hrdata[DPBS_STAT_B +: 9] == $past(port_b_rdata);
  endproperty
  a_stat_b: assert property (p_stat_b) else $error("status read of port B wrong");

  c_both: cover property (!port_a_select_n && !port_b_select_n);
  c_wr_rd: cover property (!port_a_select_n && !port_a_read_write_n ##1 !port_b_select_n && port_b_read_write_n);
  c_pipe: cover property (pipe_a && !port_a_select_n && port_a_read_write_n);
  c_wide: cover property (we_b && wid_b == DPBS_W9);
  c_thru_b: cover property (we_b && wmode_b);

endmodule

// ### verification/dpbs_fabric.sv
/*
  Fabric-side driver of one RAM port, called by the bench per access.
  Assumes the width input follows the port's width code while idle.
*/
`timescale 1ns/1ps
module dpbs_fabric
  import dpbs_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic [1:0]  width,
  output logic             select_n,
  output logic             read_write_n,
  output logic      [11:0] address,
  output logic      [8:0]  wdata
);
  // ----------------------------------------
  // Idle state
  // ----------------------------------------
  initial begin
    select_n     = 1'b1;
    read_write_n = 1'b1;
    address      = 12'h000;
    wdata        = 9'h000;
  end

  // ----------------------------------------
  // One access, after gap idle cycles
  // ----------------------------------------
  task automatic access(input int gap, input logic rw, input logic [11:0] a, input logic [8:0] d);
    logic [11:0] lim;
    logic [11:0] am;
    repeat (gap) @(posedge hclk);
    @(posedge hclk);
    lim          = 12'hFFF >> width;
    am           = a & lim;
    select_n     <= 1'b0;
    read_write_n <= rw;
    address      <= am;
    wdata        <= d;
    @(posedge hclk);
    select_n     <= 1'b1;
    read_write_n <= ~rw;
    address      <= ~am & lim;
    wdata        <= ~d;
  endtask
endmodule

// ### verification/dpbs_tb_top.sv
/*
  Self-checking bench: AHB-Lite setup of the ports, fabric accesses.
  Assumes one 10 MHz clock for the bus and both ports.
*/
`timescale 1ns/1ps
module dpbs_tb_top
  import dpbs_pkg::*;
;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        a_sel_n;
  logic        a_rw_n;
  logic [11:0] a_addr;
  logic [8:0]  a_wd;
  logic [8:0]  a_rd;
  logic        b_sel_n;
  logic        b_rw_n;
  logic [11:0] b_addr;
  logic [8:0]  b_wd;
  logic [8:0]  b_rd;
  logic [1:0]  a_wid;
  logic [1:0]  b_wid;
  logic [31:0] rd;
  logic [3:0]  nib;
  int          error_cnt;
  int          num_checks;

  // ----------------------------------------
  // Clock and instances
  // ----------------------------------------
  initial hclk = 1'b0;
  always #50 hclk = ~hclk;

  dpbs_top i_dpbs_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .port_a_select_n(a_sel_n), .port_a_read_write_n(a_rw_n), .port_a_address(a_addr),
    .port_a_wdata(a_wd), .port_a_rdata(a_rd),
    .port_b_select_n(b_sel_n), .port_b_read_write_n(b_rw_n), .port_b_address(b_addr),
    .port_b_wdata(b_wd), .port_b_rdata(b_rd)
  );

  dpbs_fabric i_dpbs_fabric_a (.hclk(hclk), .width(a_wid), .select_n(a_sel_n),
    .read_write_n(a_rw_n), .address(a_addr), .wdata(a_wd));
  dpbs_fabric i_dpbs_fabric_b (.hclk(hclk), .width(b_wid), .select_n(b_sel_n),
    .read_write_n(b_rw_n), .address(b_addr), .wdata(b_wd));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic wrap_up;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic set_cfg(input logic [11:0] c);
    bus(1'b1, DPBS_CFG_OFS, {20'h0, c}, rd);
    bus(1'b0, DPBS_CFG_OFS, 32'h0, rd);
    chk(rd, {20'h0, c});
    a_wid <= c[1:0];
    b_wid <= c[9:8];
  endtask

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    #(2000 * 100);
    error_cnt++;
    wrap_up();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    error_cnt  = 0;
    num_checks = 0;
    hresetn    = 1'b0;
    hsel       = 1'b0;
    haddr      = 32'h0;
    htrans     = 2'h0;
    hwrite     = 1'b0;
    hsize      = 3'h2;
    hwdata     = 32'h0;
    a_wid      = 2'h0;
    b_wid      = 2'h0;
    nib        = 4'hD;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    #1 chk({23'h0, a_rd}, 32'h0);
    chk({23'h0, b_rd}, 32'h0);
    bus(1'b0, DPBS_CFG_OFS, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1'b1, 32'h0000_0008, 32'hFFFF_FFFF, rd);
    bus(1'b0, 32'h0000_0008, 32'h0, rd);
    chk(rd, 32'h0);
    set_cfg(12'h303);
    i_dpbs_fabric_a.access(0, 1'b0, 12'h005, 9'h1A5);
    #1 chk({23'h0, a_rd}, 32'h0);
    i_dpbs_fabric_b.access(0, 1'b1, 12'h005, 9'h000);
    #1 chk({23'h0, b_rd}, 32'h1A5);
    repeat (3) @(posedge hclk);
    #1 chk({23'h0, b_rd}, 32'h1A5);
    bus(1'b0, DPBS_STAT_OFS, 32'h0, rd);
    chk(rd, 32'h01A5_0000);
    set_cfg(12'h70B);
    i_dpbs_fabric_a.access(1, 1'b0, 12'h006, 9'h0F3);
    #1 chk({23'h0, a_rd}, 32'h0F3);
    i_dpbs_fabric_a.access(0, 1'b1, 12'h005, 9'h1FF);
    #1 chk({23'h0, a_rd}, 32'h1A5);
    i_dpbs_fabric_b.access(0, 1'b1, 12'h006, 9'h000);
    #1 chk({23'h0, b_rd}, 32'h1A5);
    @(posedge hclk);
    #1 chk({23'h0, b_rd}, 32'h0F3);
    set_cfg(12'h200);
    for (int i = 0; i < 4; i++) begin
      i_dpbs_fabric_a.access(0, 1'b0, 12'(64 + i), {8'hFF, nib[i]});
    end
    i_dpbs_fabric_b.access(0, 1'b1, 12'd16, 9'h000);
    #1 chk({23'h0, b_rd}, 32'h00D);
    set_cfg(12'h201);
    for (int i = 0; i < 2; i++) begin
      i_dpbs_fabric_a.access(0, 1'b0, 12'(36 + i), {7'h7F, (i == 0) ? 2'b01 : 2'b10});
    end
    i_dpbs_fabric_b.access(0, 1'b1, 12'd18, 9'h000);
    #1 chk({23'h0, b_rd}, 32'h009);
    set_cfg(12'h907);
    i_dpbs_fabric_b.access(0, 1'b0, 12'd24, 9'h1FE);
    #1 chk({23'h0, b_rd}, 32'h002);
    i_dpbs_fabric_a.access(0, 1'b1, 12'h006, 9'h000);
    #1 chk({23'h0, a_rd}, 32'h1A5);
    @(posedge hclk);
    #1 chk({23'h0, a_rd}, 32'h0F2);
    @(posedge hclk);
    hresetn <= 1'b0;
    a_wid   <= 2'h0;
    b_wid   <= 2'h0;
    #1 chk({23'h0, a_rd}, 32'h0);
    chk({23'h0, b_rd}, 32'h0);
    i_dpbs_fabric_a.access(0, 1'b0, 12'd40, 9'h000);
    @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, DPBS_CFG_OFS, 32'h0, rd);
    chk(rd, 32'h0);
    set_cfg(12'h303);
    i_dpbs_fabric_b.access(0, 1'b0, 12'h007, 9'h055);
    #1 chk({23'h0, b_rd}, 32'h0);
    i_dpbs_fabric_a.access(0, 1'b1, 12'h005, 9'h000);
    #1 chk({23'h0, a_rd}, 32'h1A5);
    wrap_up();
  end
endmodule
